// File: vpf_framer.sv
`default_nettype none
module vpf_framer
    import vpf_pkg::*;
#(
    parameter int SOF_CYCLES = SOF_CYC,
    parameter int IDLE_CYCLES = IDLE_CYC,
    parameter int MIN_SYM_CYCLES = MIN_SYM_CYC,
    parameter int BIT_CYCLES = BIT_CYC
)
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic DIG_LOOP,
    input wire logic ANA_LOOP,
    input wire logic LINK_RX_DIGITAL_IN,
    output logic LINK_TX_DIGITAL_OUT,
    input wire logic TX_START,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    output logic TX_READY,
    output logic TX_BUSY,
    input wire logic RX_SOF,
    input wire logic RX_BIT_VALID,
    input wire logic RX_BIT,
    input wire logic RX_EOD,
    output logic [7:0] RX_BYTE,
    output logic RX_BYTE_VALID,
    output logic RX_FILTERED,
    output logic [1:0] STATE_VECTOR_REGISTER,
    input wire logic STATUS_CLEAR,
    output logic BUS_IDLE
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction : crc_step

    typedef enum logic [2:0] {
        VPF_IDLE = 3'b000,
        VPF_SOF = 3'b001,
        VPF_DATA = 3'b010,
        VPF_CRC = 3'b011,
        VPF_EOD = 3'b100
    } vpf_tx_type;

    // ----------------------------------------
    // input path and loopback
    // ----------------------------------------
    logic tx_level_r;
    logic s1_r, s2_r, s3_r, rx_sync_r;
    logic rx_src;
    logic rx_filt;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            rx_sync_r <= 1'b0;
        end else begin
            s1_r <= LINK_RX_DIGITAL_IN;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                rx_sync_r <= s3_r;
            end
        end
    end

    assign rx_src = DIG_LOOP ? tx_level_r : rx_sync_r;
    assign LINK_TX_DIGITAL_OUT = DIG_LOOP ? 1'b0 : tx_level_r;

    vpf_rx_filter u_filt (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .raw_in(rx_src),
        .filt_out(rx_filt)
    );
    assign RX_FILTERED = rx_filt;

    // ----------------------------------------
    // idle detection and analog loopback hold
    // ----------------------------------------
    logic [15:0] idle_cnt_r;
    logic ana_prev_r;
    logic hold_r;
    logic ana_exit;

    assign ana_exit = ana_prev_r && !ANA_LOOP;

    // leaving analog loopback restarts the idle count: a fresh idle is needed
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            idle_cnt_r <= 16'h0000;
        end else if (rx_filt || ana_exit) begin
            idle_cnt_r <= 16'h0000;
        end else if (idle_cnt_r != 16'(IDLE_CYCLES)) begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
        end
    end
    // latch moves on the falling edge, so the count alone lags it
    assign BUS_IDLE = (idle_cnt_r == 16'(IDLE_CYCLES)) && !rx_filt;

    // exit of analog loopback arms a hold released only by idle bus
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ana_prev_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            ana_prev_r <= ANA_LOOP;
            if (ana_exit) begin
                hold_r <= 1'b1;
            end else if (hold_r && BUS_IDLE) begin
                hold_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pulse width check
    // ----------------------------------------
    logic filt_prev_r;
    logic [15:0] pulse_cnt_r;
    logic short_pulse;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            filt_prev_r <= 1'b1;
            pulse_cnt_r <= 16'hffff;
        end else begin
            filt_prev_r <= rx_filt;
            if (filt_prev_r != rx_filt) begin
                pulse_cnt_r <= 16'h0000;
            end else if (pulse_cnt_r != 16'hffff) begin
                pulse_cnt_r <= pulse_cnt_r + 16'h0001;
            end
        end
    end
    // pulse ended by an edge before reaching the shortest symbol
    assign short_pulse = (filt_prev_r != rx_filt) &&
                         (pulse_cnt_r < 16'(MIN_SYM_CYCLES));

    // ----------------------------------------
    // transmit framer
    // ----------------------------------------
    vpf_tx_type st_r;
    logic [15:0] tcnt_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic last_r;
    logic [3:0] nbytes_r;
    logic [7:0] tx_crc_r;
    logic tcnt_done;
    logic [7:0] crc_fin;

    assign crc_fin = ~crc_step(tx_crc_r, sh_r[7]);
    assign tcnt_done = (tcnt_r == 16'h0000);
    assign TX_BUSY = (st_r != VPF_IDLE);
    assign TX_READY = (st_r == VPF_IDLE) && !hold_r && BUS_IDLE;

    // simplified level coding: one fixed slot per bit, level is the bit
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_r <= VPF_IDLE;
            tcnt_r <= 16'h0000;
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            last_r <= 1'b0;
            nbytes_r <= 4'h0;
            tx_crc_r <= CRC_PRESET;
            tx_level_r <= 1'b0;
        end else begin
            case (st_r)
                VPF_IDLE: begin
                    tx_level_r <= 1'b0;
                    if (TX_START && TX_READY) begin
                        st_r <= VPF_SOF;
                        tcnt_r <= 16'(SOF_CYCLES - 1);
                        tx_level_r <= 1'b1;
                        tx_crc_r <= CRC_PRESET;
                        sh_r <= TX_DATA;
                        last_r <= TX_LAST;
                        nbytes_r <= 4'h1;
                        bit_r <= 3'h7;
                    end
                end
                VPF_SOF: begin
                    if (tcnt_done) begin
                        st_r <= VPF_DATA;
                        tcnt_r <= 16'(BIT_CYCLES - 1);
                        tx_level_r <= sh_r[7];
                    end else begin
                        tcnt_r <= tcnt_r - 16'h0001;
                    end
                end
                VPF_DATA, VPF_CRC: begin
                    if (tcnt_done) begin
                        if (st_r == VPF_DATA) begin
                            tx_crc_r <= crc_step(tx_crc_r, sh_r[7]);
                        end
                        sh_r <= {sh_r[6:0], 1'b0};
                        tcnt_r <= 16'(BIT_CYCLES - 1);
                        tx_level_r <= sh_r[6];
                        bit_r <= bit_r - 3'h1;
                        if (bit_r == 3'h0) begin
                            if (st_r == VPF_DATA && !last_r &&
                                nbytes_r != 4'(MAX_BYTES)) begin
                                sh_r <= TX_DATA;
                                tx_level_r <= TX_DATA[7];
                                last_r <= TX_LAST;
                                nbytes_r <= nbytes_r + 4'h1;
                            end else if (st_r == VPF_DATA) begin
                                st_r <= VPF_CRC;
                                sh_r <= crc_fin;
                                tx_level_r <= crc_fin[7];
                            end else begin
                                st_r <= VPF_EOD;
                                tcnt_r <= 16'(SOF_CYCLES - 1);
                                tx_level_r <= 1'b0;
                            end
                        end
                    end else begin
                        tcnt_r <= tcnt_r - 16'h0001;
                    end
                end
                VPF_EOD: begin
                    if (tcnt_done) begin
                        st_r <= VPF_IDLE;
                    end else begin
                        tcnt_r <= tcnt_r - 16'h0001;
                    end
                end
                default: begin
                    st_r <= VPF_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // receive byte assembly and CRC check
    // ----------------------------------------
    logic [7:0] rx_crc_r;
    logic [7:0] rx_sh_r;
    logic [2:0] rx_cnt_r;
    logic rx_bv_r;
    logic [7:0] rx_byte_r;
    logic crc_err_r, inv_r;
    logic crc_bad;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rx_crc_r <= CRC_PRESET;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_bv_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_bv_r <= 1'b0;
            if (RX_SOF) begin
                rx_crc_r <= CRC_PRESET;
                rx_cnt_r <= 3'h0;
            end else if (RX_BIT_VALID) begin
                rx_crc_r <= crc_step(rx_crc_r, RX_BIT);
                rx_sh_r <= {rx_sh_r[6:0], RX_BIT};
                rx_cnt_r <= rx_cnt_r + 3'h1;
                if (rx_cnt_r == 3'h7) begin
                    rx_byte_r <= {rx_sh_r[6:0], RX_BIT};
                    rx_bv_r <= 1'b1;
                end
            end
        end
    end
    assign RX_BYTE = rx_byte_r;
    assign RX_BYTE_VALID = rx_bv_r;
    assign crc_bad = RX_EOD && (rx_crc_r != CRC_GOOD);

    // set wins over clear; a good end of data touches no flag
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            crc_err_r <= 1'b0;
            inv_r <= 1'b0;
        end else begin
            crc_err_r <= crc_bad | (crc_err_r & ~STATUS_CLEAR);
            inv_r <= short_pulse | (inv_r & ~STATUS_CLEAR);
        end
    end
    assign STATE_VECTOR_REGISTER = {inv_r, crc_err_r};
endmodule : vpf_framer
`default_nettype wire

// File: vpf_pkg.sv
`default_nettype none
package vpf_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int FILT_MAX = 15;
    localparam int FILT_W = 4;
    localparam logic [3:0] FILT_TOP = 4'hf;
    localparam logic [3:0] FILT_BOT = 4'h0;
    localparam logic [3:0] FILT_RST = 4'hf;
    localparam logic FILT_LATCH_RST = 1'b1;
    localparam int MAX_BYTES = 12;
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [7:0] CRC_PRESET = 8'hff;
    localparam logic [7:0] CRC_GOOD = 8'hc4;
    localparam int SOF_US = 200;
    localparam int EOD_US = 200;
    localparam int IDLE_US = 300;
    localparam int MIN_SYM_US = 34;
    localparam int SOF_CYC = SOF_US * (CLK_HZ / 1_000_000);
    localparam int IDLE_CYC = IDLE_US * (CLK_HZ / 1_000_000);
    localparam int MIN_SYM_CYC = MIN_SYM_US * (CLK_HZ / 1_000_000);
    localparam int BIT_US = 64;
    localparam int BIT_CYC = BIT_US * (CLK_HZ / 1_000_000);
    localparam int VSVR_CRC_BIT = 0;
    localparam int VSVR_INV_BIT = 1;
    localparam int VSVR_W = 2;
endpackage : vpf_pkg
`default_nettype wire

// File: vpf_rx_filter.sv
`default_nettype none
module vpf_rx_filter
    import vpf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic raw_in,
    output logic filt_out
);
    // ----------------------------------------
    // sample on rise, step on fall
    // ----------------------------------------
    logic sample_r;
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic latch_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            sample_r <= 1'b1;
        end else begin
            sample_r <= raw_in;
        end
    end

    always_comb begin
        count_nxt = count_r;
        if (sample_r && count_r != FILT_TOP) begin
            count_nxt = count_r + 4'h1;
        end else if (!sample_r && count_r != FILT_BOT) begin
            count_nxt = count_r - 4'h1;
        end
    end

    // reset leaves a known high output before any edge
    always_ff @(negedge clk) begin
        if (rst) begin
            count_r <= FILT_RST;
            latch_r <= FILT_LATCH_RST;
        end else begin
            count_r <= count_nxt;
            if (count_nxt == FILT_TOP) begin
                latch_r <= 1'b1;
            end else if (count_nxt == FILT_BOT) begin
                latch_r <= 1'b0;
            end
            // otherwise hold
        end
    end

    assign filt_out = latch_r;
endmodule : vpf_rx_filter
`default_nettype wire

// File: vpf_framer_monitor.sv
`default_nettype none
module vpf_framer_monitor (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic DIG_LOOP,
    input wire logic ANA_LOOP,
    input wire logic LINK_RX_DIGITAL_IN,
    input wire logic LINK_TX_DIGITAL_OUT,
    input wire logic TX_START,
    input wire logic TX_READY,
    input wire logic TX_BUSY,
    input wire logic RX_SOF,
    input wire logic RX_BIT_VALID,
    input wire logic RX_EOD,
    input wire logic RX_BYTE_VALID,
    input wire logic RX_FILTERED,
    input wire logic [1:0] STATE_VECTOR_REGISTER,
    input wire logic STATUS_CLEAR,
    input wire logic BUS_IDLE
);
    // ------------------------------------
    // helper counters
    // ------------------------------------
    logic [4:0] hi_r;
    logic [4:0] lo_r;
    logic [2:0] bc_r;
    // digital loopback feeds the filter internally, so pin history restarts there
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || DIG_LOOP || !LINK_RX_DIGITAL_IN) hi_r <= 5'h00;
        else if (hi_r != 5'h1f) hi_r <= hi_r + 5'h01;
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || DIG_LOOP || LINK_RX_DIGITAL_IN) lo_r <= 5'h00;
        else if (lo_r != 5'h1f) lo_r <= lo_r + 5'h01;
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || RX_SOF) bc_r <= 3'h0;
        else if (RX_BIT_VALID) bc_r <= bc_r + 3'h1;
    end
    // ------------------------------------
    // properties
    // ------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sequence s_take;
        !DIG_LOOP && TX_START && TX_READY;
    endsequence
    sequence s_sof_run;
        (TX_BUSY && LINK_TX_DIGITAL_OUT) [*8];
    endsequence
    a_loop_tx_quiet: assert property (DIG_LOOP && $past(DIG_LOOP) |-> !LINK_TX_DIGITAL_OUT) else $error("tx driven in loopback");
    a_ana_exit_hold: assert property ($fell(ANA_LOOP) |=> !TX_READY) else $error("ready right after analog loop");
    a_filt_low_end: assert property (lo_r >= 5'd22 |-> !RX_FILTERED) else $error("filter stuck high");
    a_filt_high_end: assert property (hi_r >= 5'd22 |-> RX_FILTERED) else $error("filter stuck low");
    a_tx_sof_run: assert property (s_take |=> s_sof_run) else $error("start symbol missing");
    a_ready_idle: assert property (TX_READY |-> BUS_IDLE && !TX_BUSY) else $error("ready without idle bus");
    a_idle_passive: assert property (BUS_IDLE |-> !RX_FILTERED) else $error("idle while active");
    a_byte_after_bit: assert property (RX_BIT_VALID && bc_r == 3'h7 |=> RX_BYTE_VALID) else $error("byte not delivered");
    a_byte_cause: assert property (RX_BYTE_VALID |-> $past(RX_BIT_VALID)) else $error("stray byte");
    a_crc_sticky: assert property (STATE_VECTOR_REGISTER[0] && !STATUS_CLEAR |=> STATE_VECTOR_REGISTER[0]) else $error("crc flag lost");
    a_crc_cause: assert property ($rose(STATE_VECTOR_REGISTER[0]) |-> $past(RX_EOD) || $past(RX_EOD, 2)) else $error("crc flag without end");
endmodule : vpf_framer_monitor
`default_nettype wire

// File: vpf_xcvr_model.sv
`default_nettype none
module vpf_xcvr_model #(
    parameter int LAG = 1
) (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic echo,
    input wire logic bus_level,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------
    // transceiver loopback with path delay
    // ------------------------------------
    logic [7:0] sh = 8'h00;
    always @(posedge clk) sh <= {sh[6:0], tx_line};
    // passive bus is pulled low, so idle reads 0
    assign rx_line = echo ? sh[LAG] : bus_level;
endmodule : vpf_xcvr_model
`default_nettype wire

// File: vpf_framer_test.sv
`default_nettype none
module vpf_framer_test;
    import vpf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------
    // bench signals and models
    // ------------------------------------
    localparam int SOF = 20;
    localparam int BIT = 4;
    logic clk = 1'b0, rst = 1'b1, dig = 1'b0, ana = 1'b0, start = 1'b0;
    logic last = 1'b0, rsof = 1'b0, rbv = 1'b0, rbit = 1'b0, reod = 1'b0;
    logic sclr = 1'b0, echo = 1'b0, bus = 1'b0;
    logic rx_raw, tx_out, ready, busy, rvalid, filt, idle;
    logic [7:0] tdata = 8'h00;
    logic [7:0] rbyte;
    logic [1:0] svr;
    logic [31:0] seed = 32'hfaa5;
    logic [7:0] exp_q[$];
    int errors = 0;
    int n_compared = 0;
    int n;
    always #5 clk = ~clk;
    vpf_framer #(.SOF_CYCLES(SOF), .IDLE_CYCLES(40), .MIN_SYM_CYCLES(5),
        .BIT_CYCLES(BIT)) i_dut (.CLK_SYS(clk), .SYS_RST(rst),
        .DIG_LOOP(dig), .ANA_LOOP(ana), .LINK_RX_DIGITAL_IN(rx_raw),
        .LINK_TX_DIGITAL_OUT(tx_out), .TX_START(start), .TX_DATA(tdata),
        .TX_LAST(last), .TX_READY(ready), .TX_BUSY(busy), .RX_SOF(rsof),
        .RX_BIT_VALID(rbv), .RX_BIT(rbit), .RX_EOD(reod), .RX_BYTE(rbyte),
        .RX_BYTE_VALID(rvalid), .RX_FILTERED(filt),
        .STATE_VECTOR_REGISTER(svr), .STATUS_CLEAR(sclr), .BUS_IDLE(idle));
    vpf_xcvr_model #(.LAG(2)) i_xcvr (.clk(clk), .tx_line(tx_out),
        .echo(echo), .bus_level(bus), .rx_line(rx_raw));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc_step
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic wait_ready(input int lim);
        for (int k = 0; k < lim && ready !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(ready === 1'b1, "ready never came");
    endtask : wait_ready
    task automatic settle(input logic lvl, output int c);
        for (c = 0; c < 40 && filt !== lvl; c++)
            @(posedge clk);
    endtask : settle
    // bytes past the limit are offered but must not go out
    task automatic tx_frame(input int nb, input logic dl);
        logic [7:0] d[13];
        logic [7:0] c;
        logic [7:0] b;
        int m;
        m = (nb > MAX_BYTES) ? MAX_BYTES : nb;
        c = CRC_PRESET;
        for (int k = 0; k < 13; k++) begin
            seed = lfsr(seed);
            d[k] = seed[7:0];
            if (k < m) c = crc_step(c, d[k]);
        end
        wait_ready(300);
        start <= 1'b1;
        tdata <= d[0];
        last <= (nb == 1);
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk(tx_out === !dl && busy === 1'b1, "start symbol");
        repeat (SOF + 1) @(posedge clk);
        #1;
        for (int k = 0; k <= m; k++) begin
            b = (k < m) ? d[k] : ~c;
            for (int i = 7; i >= 0; i--) begin
                chk(tx_out === (b[i] & !dl), "tx bit");
                if (i == 0 && k + 1 < nb) begin
                    tdata <= d[k+1];
                    last <= (k + 2 == nb) && (nb <= MAX_BYTES);
                end
                repeat (BIT) @(posedge clk);
                #1;
            end
        end
        repeat (SOF / 2) @(posedge clk);
        chk(tx_out === 1'b0 && busy === 1'b1, "end of data");
        repeat (SOF) @(posedge clk);
        chk(busy === 1'b0, "busy after frame");
        last <= 1'b0;
        $display("tx frame of %0d bytes done", nb);
    endtask : tx_frame
    task automatic rx_frame(input int nb, input logic bad);
        logic [7:0] c;
        logic [7:0] b;
        c = CRC_PRESET;
        @(posedge clk) rsof <= 1'b1;
        @(posedge clk) rsof <= 1'b0;
        for (int k = 0; k <= nb; k++) begin
            seed = lfsr(seed);
            b = (k == nb) ? (~c ^ {7'h00, bad}) : seed[7:0];
            c = crc_step(c, b);
            exp_q.push_back(b);
            for (int i = 7; i >= 0; i--) begin
                @(posedge clk);
                rbv <= 1'b1;
                rbit <= b[i];
                @(posedge clk);
                rbv <= 1'b0;
            end
        end
        @(posedge clk) reod <= 1'b1;
        @(posedge clk) reod <= 1'b0;
        repeat (3) @(posedge clk);
        chk(svr === {1'b0, bad}, "crc flag");
        sclr <= 1'b1;
        @(posedge clk) sclr <= 1'b0;
        repeat (2) @(posedge clk);
        chk(svr === 2'b00, "flag clear");
        $display("rx frame of %0d bytes done", nb);
    endtask : rx_frame
    // registered outputs are read mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            chk(exp_q.size() > 0 && rbyte === exp_q[0], "rx byte");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        #200_000;
        errors++;
        $display("FAIL %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(filt === 1'b1 && tx_out === 1'b0 && svr === 2'b00, "reset");
        settle(1'b0, n);
        chk(n >= 14 && n <= 20, "fall delay");
        bus <= 1'b1;
        settle(1'b1, n);
        chk(n >= 15 && n <= 20, "rise delay");
        bus <= 1'b0;
        repeat (8) @(posedge clk);
        bus <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (filt !== 1'b1) n++;
        end
        chk(n == 0, "glitch passed filter");
        bus <= 1'b0;
        $display("filter test done");
        wait_ready(300);
        ana <= 1'b1;
        repeat (5) @(posedge clk);
        ana <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(ready === 1'b0, "ready after analog loop");
        repeat (4) @(posedge clk);
        #1;
        chk(ready === 1'b0, "ready before fresh idle");
        $display("analog loop test done");
        echo <= 1'b1;
        tx_frame(1, 1'b0);
        tx_frame(3, 1'b0);
        tx_frame(13, 1'b0);
        echo <= 1'b0;
        bus <= 1'b1;
        dig <= 1'b1;
        tx_frame(2, 1'b1);
        dig <= 1'b0;
        bus <= 1'b0;
        rx_frame(1, 1'b0);
        rx_frame(4, 1'b1);
        rx_frame(12, 1'b0);
        chk(exp_q.size() == 0, "rx byte count");
        end_sim;
    end
endmodule : vpf_framer_test
bind vpf_framer vpf_framer_monitor i_mon (.CLK_SYS, .SYS_RST, .DIG_LOOP,
    .ANA_LOOP, .LINK_RX_DIGITAL_IN, .LINK_TX_DIGITAL_OUT, .TX_START,
    .TX_READY, .TX_BUSY, .RX_SOF, .RX_BIT_VALID, .RX_EOD, .RX_BYTE_VALID,
    .RX_FILTERED, .STATE_VECTOR_REGISTER, .STATUS_CLEAR, .BUS_IDLE);
`default_nettype wire
